// File: core/zaab_pkg.sv
// Shared constants for the z-buffer antialias blender and video filter
package zaab_pkg;
  localparam int DEPTH_W = 18;
  localparam int SLOPE_W = 16;
  localparam int CODE_W  = 4;
  localparam int CVG_W   = 4;
  localparam int CH_W    = 8;
  localparam int CH_N    = 3;
  localparam int COL_W   = CH_W * CH_N;
  localparam int NB_W    = 5;
  localparam int NB_H    = 3;
  localparam int NB_N    = NB_W * NB_H;
  localparam int NB_CENTRE = 7;
  localparam int CVG_SHIFT = 3;
  localparam logic [CVG_W-1:0] CVG_UNITY = 4'h8;
  localparam logic [4:0]       FLAT_MAX  = 5'h10;
  localparam logic [SLOPE_W-1:0] SLOPE_ONE = 16'h0001;
  localparam logic [SLOPE_W-1:0] SLOPE_SAT = 16'hffff;
endpackage

// File: core/zaab_vfilt.sv
// Display-time silhouette filter over a 5x3 coverage/colour window
`timescale 1ns/1ps
module zaab_vfilt (
  input  wire logic                                     sys_clk,
  input  wire logic                                     nrst,
  input  wire logic                                     ce,
  input  wire logic                                     vf_valid,
  input  wire logic [zaab_pkg::NB_N*zaab_pkg::COL_W-1:0] nb_col,
  input  wire logic [zaab_pkg::NB_N*zaab_pkg::CVG_W-1:0] nb_cvg,
  output logic                                          vf_out_valid,
  output logic [zaab_pkg::COL_W-1:0]                     vf_out_col
);
  typedef struct packed {
    logic                        valid;
    logic [zaab_pkg::COL_W-1:0] col;
  } zaab_vf_t;

  // Nearest neighbours first, centre excluded
  localparam int ORDER [14] = '{6, 8, 2, 12, 1, 3, 11, 13, 5, 9, 0, 4, 10, 14};

  zaab_vf_t                    st_r;
  zaab_vf_t                    st_nxt;
  logic [zaab_pkg::COL_W-1:0] fg;
  logic [zaab_pkg::COL_W-1:0] bg;
  logic [zaab_pkg::COL_W-1:0] mix;
  logic [zaab_pkg::CVG_W-1:0] cvg;
  logic [zaab_pkg::CVG_W-1:0] inv;
  logic [12:0]                acc;
  logic                       found;

  always_comb begin
    fg    = nb_col[zaab_pkg::NB_CENTRE*zaab_pkg::COL_W +: zaab_pkg::COL_W];
    cvg   = nb_cvg[zaab_pkg::NB_CENTRE*zaab_pkg::CVG_W +: zaab_pkg::CVG_W];
    inv   = zaab_pkg::CVG_UNITY - cvg;
    bg    = fg;
    found = 1'b0;
    acc   = '0;
    mix   = fg;
    // Depth is never consulted here, only colour and coverage
    for (int k = 0; k < 14; k++) begin
      if (!found && nb_cvg[ORDER[k]*zaab_pkg::CVG_W +: zaab_pkg::CVG_W] == zaab_pkg::CVG_UNITY) begin
        bg    = nb_col[ORDER[k]*zaab_pkg::COL_W +: zaab_pkg::COL_W];
        found = 1'b1;
      end
    end
    for (int c = 0; c < zaab_pkg::CH_N; c++) begin
      acc = {5'h0, fg[c*zaab_pkg::CH_W +: zaab_pkg::CH_W]} * {9'h0, cvg}
          + {5'h0, bg[c*zaab_pkg::CH_W +: zaab_pkg::CH_W]} * {9'h0, inv};
      mix[c*zaab_pkg::CH_W +: zaab_pkg::CH_W] = acc[zaab_pkg::CVG_SHIFT +: zaab_pkg::CH_W];
    end
    st_nxt.valid = vf_valid;
    st_nxt.col   = (!found || cvg >= zaab_pkg::CVG_UNITY) ? fg : mix;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign vf_out_valid = st_r.valid;
  assign vf_out_col   = st_r.col;

  property p_full_fg;
    @(posedge sys_clk) disable iff (!nrst)
      ce && vf_valid && cvg == zaab_pkg::CVG_UNITY |=> vf_out_col == $past(fg);
  endproperty
  a_full_fg: assert property (p_full_fg) else $error("full pixel not foreground");

  property p_no_bg;
    @(posedge sys_clk) disable iff (!nrst)
      ce && vf_valid && !found |=> vf_out_col == $past(fg);
  endproperty
  a_no_bg: assert property (p_no_bg) else $error("no background yet colour changed");

  property p_zero_cvg;
    @(posedge sys_clk) disable iff (!nrst)
      ce && vf_valid && found && cvg == 4'h0 |=> vf_out_col == $past(bg);
  endproperty
  a_zero_cvg: assert property (p_zero_cvg) else $error("zero coverage not background");
endmodule

// File: core/zaab_top.sv
// Opaque-surface z-buffer blender with display-time silhouette filter
// Notes on behaviour
// - Partial pixel output is cvg*foreground plus (unity-cvg)*background.
// - Foreground is always the stored colour of the current pixel.
// - Background comes only from fully covered pixels of the 5x3 window.
// - Background choice never looks at depth.
// - Non-silhouette pixels end with full coverage; filter passes them unchanged.
// - Silhouette edges are never blended with background at render time.
// - Every write leaves a coverage value for the display filter.
// - Depth test off also disables internal-edge blending.
// - Accepted pixels write their slope code with their depth.
// - Same surface when depth difference is below the larger slope.
// - Clearly nearer pixel overwrites the stored pixel.
// - Clearly farther pixel writes nothing at all while the depth test is on.
// - Flatter fragments weigh more than edge-on ones in the blend.
// - Coverage wrap forces a strict depth compare ignoring slopes.
// - Pixel slope is the sum of absolute x and y depth gradients.
// - Stored slope is the 4-bit position of the slope's top set bit.
`timescale 1ns/1ps
module zaab_top (
  input  wire logic                                     sys_clk,
  input  wire logic                                     nrst,
  input  wire logic                                     ce,
  input  wire logic                                     opaque_surface_aa_mode,
  input  wire logic                                     depth_test_en,
  input  wire logic                                     in_valid,
  input  wire logic [zaab_pkg::DEPTH_W-1:0]              pixel_depth,
  input  wire logic [zaab_pkg::SLOPE_W-1:0]              dzdx,
  input  wire logic [zaab_pkg::SLOPE_W-1:0]              dzdy,
  input  wire logic [zaab_pkg::COL_W-1:0]                pix_col,
  input  wire logic [zaab_pkg::CVG_W-1:0]                pix_cvg,
  input  wire logic [zaab_pkg::DEPTH_W-1:0]              stored_depth,
  input  wire logic [zaab_pkg::CODE_W-1:0]               stored_depth_slope_code,
  input  wire logic [zaab_pkg::COL_W-1:0]                mem_col,
  input  wire logic [zaab_pkg::CVG_W-1:0]                mem_cvg,
  output logic                                          wr_en,
  output logic [zaab_pkg::COL_W-1:0]                     wr_col,
  output logic [zaab_pkg::CVG_W-1:0]                     wr_cvg,
  output logic [zaab_pkg::DEPTH_W-1:0]                   wr_depth,
  output logic [zaab_pkg::CODE_W-1:0]                    wr_slope_code,
  input  wire logic                                     vf_valid,
  input  wire logic [zaab_pkg::NB_N*zaab_pkg::COL_W-1:0] nb_col,
  input  wire logic [zaab_pkg::NB_N*zaab_pkg::CVG_W-1:0] nb_cvg,
  output logic                                          vf_out_valid,
  output logic [zaab_pkg::COL_W-1:0]                     vf_out_col
);
  typedef struct packed {
    logic                          wr_en;
    logic [zaab_pkg::COL_W-1:0]   col;
    logic [zaab_pkg::CVG_W-1:0]   cvg;
    logic [zaab_pkg::DEPTH_W-1:0] depth;
    logic [zaab_pkg::CODE_W-1:0]  code;
  } zaab_bl_t;

  zaab_bl_t                       st_r;
  zaab_bl_t                       st_nxt;
  logic [zaab_pkg::SLOPE_W-1:0]  abs_x;
  logic [zaab_pkg::SLOPE_W-1:0]  abs_y;
  logic [zaab_pkg::SLOPE_W:0]    slope_sum;
  logic [zaab_pkg::SLOPE_W-1:0]  slope;
  logic [zaab_pkg::SLOPE_W-1:0]  mem_slope;
  logic [zaab_pkg::SLOPE_W-1:0]  dz_max;
  logic [zaab_pkg::DEPTH_W-1:0]  diff;
  logic [zaab_pkg::CODE_W-1:0]   pcode;
  logic [4:0]                    cvg_sum;
  logic [4:0]                    flat_p;
  logic [4:0]                    flat_m;
  logic [8:0]                    wa;
  logic [8:0]                    wb;
  logic [9:0]                    wsum;
  logic [17:0]                   num;
  logic [17:0]                   quo;
  logic [zaab_pkg::COL_W-1:0]    bl_col;
  logic                          wrap;
  logic                          same;
  logic                          in_front;
  logic                          blend;
  logic                          accept;

  function automatic logic [zaab_pkg::CODE_W-1:0] msb_code(
    input logic [zaab_pkg::SLOPE_W-1:0] v
  );
    logic [zaab_pkg::CODE_W-1:0] r;
    r = '0;
    for (int i = 0; i < zaab_pkg::SLOPE_W; i++) begin
      if (v[i]) begin
        r = i[zaab_pkg::CODE_W-1:0];
      end
    end
    return r;
  endfunction

  always_comb begin
    abs_x     = dzdx[zaab_pkg::SLOPE_W-1] ? -dzdx : dzdx;
    abs_y     = dzdy[zaab_pkg::SLOPE_W-1] ? -dzdy : dzdy;
    slope_sum = {1'b0, abs_x} + {1'b0, abs_y};
    // Saturate rather than wrap so a steep polygon never looks flat
    slope     = slope_sum[zaab_pkg::SLOPE_W] ? zaab_pkg::SLOPE_SAT
                                             : slope_sum[zaab_pkg::SLOPE_W-1:0];
    pcode     = msb_code(slope);
    // Stored slope is only a power of two, so same-surface range is coarse
    mem_slope = zaab_pkg::SLOPE_ONE << stored_depth_slope_code;
    dz_max    = (slope > mem_slope) ? slope : mem_slope;
    diff      = (pixel_depth > stored_depth) ? pixel_depth - stored_depth
                                             : stored_depth - pixel_depth;
    cvg_sum   = {1'b0, pix_cvg} + {1'b0, mem_cvg};
    wrap      = cvg_sum > {1'b0, zaab_pkg::CVG_UNITY};
    in_front  = pixel_depth < stored_depth;
    same      = !wrap && (diff < {2'b00, dz_max});
    blend     = depth_test_en && opaque_surface_aa_mode && same;
    accept    = !depth_test_en || blend || in_front;
  end

  always_comb begin
    flat_p = zaab_pkg::FLAT_MAX - {1'b0, pcode};
    flat_m = zaab_pkg::FLAT_MAX - {1'b0, stored_depth_slope_code};
    wa     = {5'h0, pix_cvg} * {4'h0, flat_p};
    wb     = {5'h0, mem_cvg} * {4'h0, flat_m};
    wsum   = {1'b0, wa} + {1'b0, wb};
    num    = '0;
    quo    = '0;
    bl_col = pix_col;
    for (int c = 0; c < zaab_pkg::CH_N; c++) begin
      num = {1'b0, {9'h0, pix_col[c*zaab_pkg::CH_W +: zaab_pkg::CH_W]} * {8'h0, wa}}
          + {1'b0, {9'h0, mem_col[c*zaab_pkg::CH_W +: zaab_pkg::CH_W]} * {8'h0, wb}};
      quo = (wsum == 10'h000) ? 18'h00000 : num / {8'h00, wsum};
      if (wsum != 10'h000) begin
        bl_col[c*zaab_pkg::CH_W +: zaab_pkg::CH_W] = quo[zaab_pkg::CH_W-1:0];
      end
    end
  end

  always_comb begin
    st_nxt       = st_r;
    st_nxt.wr_en = in_valid && accept;
    // Overwrite keeps raw colour and coverage; background mixing is left to video
    st_nxt.col   = blend ? bl_col : pix_col;
    st_nxt.cvg   = blend ? cvg_sum[zaab_pkg::CVG_W-1:0] : pix_cvg;
    st_nxt.depth = pixel_depth;
    st_nxt.code  = pcode;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign wr_en         = st_r.wr_en;
  assign wr_col        = st_r.col;
  assign wr_cvg        = st_r.cvg;
  assign wr_depth      = st_r.depth;
  assign wr_slope_code = st_r.code;

  zaab_vfilt u_vfilt (
    .sys_clk      (sys_clk),
    .nrst         (nrst),
    .ce           (ce),
    .vf_valid     (vf_valid),
    .nb_col       (nb_col),
    .nb_cvg       (nb_cvg),
    .vf_out_valid (vf_out_valid),
    .vf_out_col   (vf_out_col)
  );

  property p_far_skip;
    @(posedge sys_clk) disable iff (!nrst)
      ce && in_valid && depth_test_en && !same && !in_front |=> !wr_en;
  endproperty
  a_far_skip: assert property (p_far_skip) else $error("farther pixel was written");

  property p_near_write;
    @(posedge sys_clk) disable iff (!nrst)
      ce && in_valid && depth_test_en && in_front && !same
      |=> wr_en && wr_col == $past(pix_col) && wr_cvg == $past(pix_cvg);
  endproperty
  a_near_write: assert property (p_near_write) else $error("nearer pixel not overwritten");

  property p_wrap_strict;
    @(posedge sys_clk) disable iff (!nrst)
      ce && in_valid && depth_test_en && cvg_sum > 5'h08
      |=> wr_en == $past(pixel_depth < stored_depth);
  endproperty
  a_wrap_strict: assert property (p_wrap_strict) else $error("wrap compare not strict");

  property p_no_depth;
    @(posedge sys_clk) disable iff (!nrst)
      ce && in_valid && !depth_test_en
      |=> wr_en && wr_col == $past(pix_col) && wr_cvg == $past(pix_cvg);
  endproperty
  a_no_depth: assert property (p_no_depth) else $error("blend with depth test off");

  property p_blend_cvg;
    @(posedge sys_clk) disable iff (!nrst)
      ce && in_valid && depth_test_en && opaque_surface_aa_mode && same
      |=> wr_en && wr_cvg == $past(pix_cvg) + $past(mem_cvg);
  endproperty
  a_blend_cvg: assert property (p_blend_cvg) else $error("blend coverage not summed");

  property p_same_range;
    @(posedge sys_clk) disable iff (!nrst)
      ce && in_valid && depth_test_en && opaque_surface_aa_mode && !wrap
      && diff < {2'b00, slope} |=> wr_en;
  endproperty
  a_same_range: assert property (p_same_range) else $error("same surface rejected");

  property p_code;
    @(posedge sys_clk) disable iff (!nrst)
      ce && in_valid && accept && slope != 16'h0000
      |=> wr_slope_code == $past(pcode) && (($past(slope) >> wr_slope_code) == 16'h0001)
          && wr_depth == $past(pixel_depth);
  endproperty
  a_code: assert property (p_code) else $error("slope code wrong");

  property p_hold;
    @(posedge sys_clk) disable iff (!nrst)
      !ce |=> $stable(wr_en) && $stable(wr_col) && $stable(wr_cvg);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved with enable low");
endmodule

// File: bench/zaab_fb_model.sv
// Frame-buffer pixel model behind the blender
`timescale 1ns/1ps
module zaab_fb_model (
  input  wire logic        sys_clk,
  input  wire logic        ld,
  input  wire logic [17:0] ld_depth,
  input  wire logic [3:0]  ld_code,
  input  wire logic [23:0] ld_col,
  input  wire logic [3:0]  ld_cvg,
  input  wire logic        wr_en,
  input  wire logic [17:0] wr_depth,
  input  wire logic [3:0]  wr_slope_code,
  input  wire logic [23:0] wr_col,
  input  wire logic [3:0]  wr_cvg,
  output logic      [17:0] stored_depth = 18'h0,
  output logic      [3:0]  stored_depth_slope_code = 4'h0,
  output logic      [23:0] mem_col = 24'h0,
  output logic      [3:0]  mem_cvg = 4'h0
);
  // Preload wins so a scenario can place any stored surface
  always @(posedge sys_clk) begin
    if (ld) begin
      stored_depth <= ld_depth;
      stored_depth_slope_code <= ld_code;
      mem_col <= ld_col;
      mem_cvg <= ld_cvg;
    end else if (wr_en) begin
      stored_depth <= wr_depth;
      stored_depth_slope_code <= wr_slope_code;
      mem_col <= wr_col;
      mem_cvg <= wr_cvg;
    end
  end
endmodule

// File: bench/zaab_top_tb_top.sv
// Self-checking bench for the blender and silhouette filter
`timescale 1ns/1ps
module zaab_top_tb_top;
  logic         sys_clk = 1'b0;
  logic         nrst = 1'b0;
  logic         ce = 1'b1;
  logic         md = 1'b0;
  logic         dt = 1'b0;
  logic         in_valid = 1'b0;
  logic [17:0]  pz = 18'h0;
  logic [15:0]  dx = 16'h0;
  logic [15:0]  dy = 16'h0;
  logic [23:0]  pcol = 24'h0;
  logic [3:0]   pcvg = 4'h0;
  logic [17:0]  sdep;
  logic [3:0]   scode;
  logic [23:0]  mcol;
  logic [3:0]   mcvg;
  logic         ld = 1'b0;
  logic [17:0]  ld_depth = 18'h0;
  logic [3:0]   ld_code = 4'h0;
  logic [23:0]  ld_col = 24'h0;
  logic [3:0]   ld_cvg = 4'h0;
  logic         wr_en;
  logic [23:0]  wr_col;
  logic [3:0]   wr_cvg;
  logic [17:0]  wr_depth;
  logic [3:0]   wr_code;
  logic         vf_valid = 1'b0;
  logic [359:0] nb_col = 360'h0;
  logic [59:0]  nb_cvg = 60'h0;
  logic         vf_out_valid;
  logic [23:0]  vf_out_col;
  int           miscompares = 0;
  int           n_compared = 0;
  always #5 sys_clk = ~sys_clk;
  zaab_top zaab_top_inst (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
    .opaque_surface_aa_mode(md), .depth_test_en(dt), .in_valid(in_valid), .pixel_depth(pz),
    .dzdx(dx), .dzdy(dy), .pix_col(pcol), .pix_cvg(pcvg), .stored_depth(sdep),
    .stored_depth_slope_code(scode), .mem_col(mcol), .mem_cvg(mcvg), .wr_en(wr_en),
    .wr_col(wr_col), .wr_cvg(wr_cvg), .wr_depth(wr_depth), .wr_slope_code(wr_code),
    .vf_valid(vf_valid), .nb_col(nb_col), .nb_cvg(nb_cvg), .vf_out_valid(vf_out_valid),
    .vf_out_col(vf_out_col));
  zaab_fb_model zaab_fb_model_inst (.sys_clk(sys_clk), .ld(ld), .ld_depth(ld_depth),
    .ld_code(ld_code), .ld_col(ld_col), .ld_cvg(ld_cvg), .wr_en(wr_en), .wr_depth(wr_depth),
    .wr_slope_code(wr_code), .wr_col(wr_col), .wr_cvg(wr_cvg), .stored_depth(sdep),
    .stored_depth_slope_code(scode), .mem_col(mcol), .mem_cvg(mcvg));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic frag(input logic t, input logic m, input logic [17:0] sd, input logic [3:0] sc,
                      input logic [23:0] scl, input logic [3:0] scv, input logic [17:0] z,
                      input logic [15:0] gx, input logic [15:0] gy, input logic [23:0] c,
                      input logic [3:0] v, input logic e, input logic [23:0] ec,
                      input logic [3:0] ev, input logic [3:0] ek);
    @(posedge sys_clk);
    ld <= 1'b1;
    {ld_depth, ld_code, ld_col, ld_cvg} <= {sd, sc, scl, scv};
    @(posedge sys_clk);
    ld <= 1'b0;
    {dt, md, in_valid} <= {t, m, 1'b1};
    {pz, dx, dy, pcol, pcvg} <= {z, gx, gy, c, v};
    @(posedge sys_clk);
    in_valid <= 1'b0;
    #1;
    chk("wr_en", wr_en, e);
    if (e) begin
      chk("wr_col", wr_col, ec);
      chk("wr_cvg", wr_cvg, ev);
      chk("wr_depth", wr_depth, z);
      chk("wr_slope_code", wr_code, ek);
    end
  endtask
  task automatic vf(input logic [23:0] fg, input logic [3:0] c, input int fi, input int pi,
                    input logic [23:0] ev);
    logic [359:0] col;
    logic [59:0]  cv;
    col = {15{24'h5a5a5a}};
    cv = 60'h0;
    col[7*24+:24] = fg;
    cv[7*4+:4] = c;
    if (fi >= 0) begin
      col[fi*24+:24] = 24'h00c0f0;
      cv[fi*4+:4] = 4'h8;
    end
    if (pi >= 0) begin
      col[pi*24+:24] = 24'h111111;
      cv[pi*4+:4] = 4'h7;
    end
    @(posedge sys_clk);
    {vf_valid, nb_col, nb_cvg} <= {1'b1, col, cv};
    @(posedge sys_clk);
    vf_valid <= 1'b0;
    #1;
    chk("vf_out_valid", vf_out_valid, 1'b1);
    chk("vf_out_col", vf_out_col, ev);
  endtask
  task automatic t_reset;
    #1;
    chk("wr_en", wr_en, 1'b0);
    chk("vf_out_valid", vf_out_valid, 1'b0);
  endtask
  // Farther fragment still written, no blend, while depth test is off
  task automatic t_depth_off;
    frag(0, 1, 18'h001f0, 4'h0, 24'h0000ff, 4'h4, 18'h00200, 16'h0010, 16'hfff0, 24'hff0000,
         4'h4, 1, 24'hff0000, 4'h4, 4'h5);
  endtask
  // Depth gap beyond the 8000 slope keeps the first one a clear overwrite
  task automatic t_near_far;
    frag(1, 1, 18'h0c000, 4'h0, 24'h00ff00, 4'h2, 18'h00100, 16'h4000, 16'hc000, 24'h123456,
         4'h3, 1, 24'h123456, 4'h3, 4'hf);
    frag(1, 1, 18'h00300, 4'h0, 24'h00ff00, 4'h2, 18'h00400, 16'h0001, 16'h0000, 24'h123456,
         4'h3, 0, 24'h0, 4'h0, 4'h0);
  endtask
  // Stored slope code 2 sets the same-surface range to 4
  task automatic t_same;
    frag(1, 1, 18'h01000, 4'h2, 24'h00ff58, 4'h4, 18'h01002, 16'h0001, 16'h0000, 24'hff0058,
         4'h2, 1, 24'h5ca258, 4'h6, 4'h0);
    frag(1, 1, 18'h01000, 4'h0, 24'h00ff58, 4'h4, 18'h01003, 16'h0004, 16'h0000, 24'hff0058,
         4'h2, 1, 24'h4db158, 4'h6, 4'h2);
    frag(1, 1, 18'h01000, 4'h2, 24'h00ff58, 4'h4, 18'h01004, 16'h0001, 16'h0000, 24'hff0058,
         4'h2, 0, 24'h0, 4'h0, 4'h0);
    frag(1, 1, 18'h01000, 4'h2, 24'h00ff58, 4'h4, 18'h00ffc, 16'h0001, 16'h0000, 24'hff0058,
         4'h2, 1, 24'hff0058, 4'h2, 4'h0);
    frag(1, 0, 18'h01000, 4'h2, 24'h00ff58, 4'h4, 18'h01002, 16'h0001, 16'h0000, 24'hff0058,
         4'h2, 0, 24'h0, 4'h0, 4'h0);
  endtask
  // Coverage sum 10 wraps, so only the strict compare counts
  task automatic t_wrap;
    frag(1, 1, 18'h01000, 4'h2, 24'h00ff58, 4'h4, 18'h00fff, 16'h0001, 16'h0000, 24'hff0058,
         4'h6, 1, 24'hff0058, 4'h6, 4'h0);
    frag(1, 1, 18'h01000, 4'h2, 24'h00ff58, 4'h4, 18'h01001, 16'h0001, 16'h0000, 24'hff0058,
         4'h6, 0, 24'h0, 4'h0, 4'h0);
  endtask
  // Enable low must freeze the write shown one cycle earlier
  task automatic t_hold;
    @(posedge sys_clk);
    {dt, md, in_valid, pcol, pcvg} <= {1'b0, 1'b0, 1'b1, 24'habcdef, 4'h5};
    @(posedge sys_clk);
    ce <= 1'b0;
    pcol <= 24'h010203;
    @(posedge sys_clk);
    ce <= 1'b1;
    in_valid <= 1'b0;
    #1;
    chk("hold wr_en", wr_en, 1'b1);
    chk("hold wr_col", wr_col, 24'habcdef);
    chk("hold wr_cvg", wr_cvg, 4'h5);
  endtask
  task automatic t_vfilt;
    vf(24'h804010, 4'h2, 8, 6, 24'h20a0b8);
    vf(24'h804010, 4'h0, 8, 6, 24'h00c0f0);
    vf(24'h804010, 4'h2, 14, 6, 24'h20a0b8);
    vf(24'h804010, 4'h8, 8, 6, 24'h804010);
    vf(24'h804010, 4'h2, -1, 6, 24'h804010);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset;
    t_depth_off;
    t_near_far;
    t_same;
    t_wrap;
    t_hold;
    t_vfilt;
    print_verdict;
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    miscompares++;
    print_verdict;
  end
endmodule
